// >>> fws_ctrl.sv
// Host-side controller that runs reads, writes and status polling on a parallel
// NOR flash, with an APB register front end.
// Assumes an external pull-up on the shared ready/busy line and a 50 MHz pclk.
//
// Summary of operation
// - Host reads status twice and compares toggle_bit_one; equal means done.
// - Still toggling with timeout_flag high: recheck; still toggling means failure.
// - Interrupted polling restarts from the first read.
// - After timeout_flag failure the host writes the reset command.
// - Host may skip erase_timer_bit only if commands come under 50 us apart.
// - Host checks erase_timer_bit before and after each added sector command.
// - Reset command is one write of F0 to any address.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fws_ctrl
  import fws_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash strobes and address
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] flash_addr,
  // Flash data lines, two-way
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  // Shared open-drain ready line, sampled only
  input wire logic ready_busy_n
);

  typedef enum logic [3:0] {
    S_IDLE, S_READ, S_WRITE, S_POLL_FIRST, S_POLL_SECOND, S_POLL_RECHECK,
    S_RESET_WRITE, S_SECT_PRE, S_SECT_WRITE, S_SECT_POST
  } fws_state_type;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) || (a == OFS_STATUS);
  endfunction : mapped

  fws_state_type state_reg;
  logic [2:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] first_reg;
  logic busy_reg;
  logic done_reg;
  logic pass_reg;
  logic fail_reg;
  logic accept_reg;
  logic issue_reg;
  logic fail_pending_reg;
  fws_req_type req_reg;

  logic setup_phase;
  logic access_phase;
  logic cmd_write;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [DATA_W:0] sync_out;
  logic ready_sync;
  logic [DATA_W-1:0] data_sync;
  fws_pins_type pins;

  // Pin inputs cross into pclk through two flops
  fws_sync #(
    .WIDTH(DATA_W + 1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({ready_busy_n, data_lines_in}),
    .sync_out(sync_out)
  );
  assign ready_sync = sync_out[DATA_W];
  assign data_sync = sync_out[DATA_W-1:0];

  fws_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(issue_reg),
    .req(req_reg),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .data_in(data_sync),
    .pins(pins)
  );

  assign chip_select_n = pins.chip_select_n;
  assign output_strobe_n = pins.output_strobe_n;
  assign write_strobe_n = pins.write_strobe_n;
  assign flash_addr = pins.addr;
  assign data_lines_out = pins.data_out;
  assign data_lines_oe = pins.data_oe;

  // APB handshake: zero wait states, read data captured in setup
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = access_phase;
  assign pslverr = access_phase && (!mapped(paddr) || (pwrite && paddr == OFS_CTRL && busy_reg));
  assign cmd_write = access_phase && pwrite && paddr == OFS_CTRL && !busy_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata <= {29'h0000000, op_reg};
        OFS_ADDR: prdata <= {12'h000, addr_reg};
        OFS_WDATA: prdata <= {24'h000000, wdata_reg};
        OFS_STATUS: begin
          prdata <= '0;
          prdata[ST_BUSY] <= busy_reg;
          prdata[ST_DONE] <= done_reg;
          prdata[ST_PASS] <= pass_reg;
          prdata[ST_FAIL] <= fail_reg;
          prdata[ST_READY] <= ready_sync;
          prdata[ST_ACCEPT] <= accept_reg;
          prdata[ST_RDATA_LSB +: DATA_W] <= rdata_reg;
        end
        default: prdata <= '0;
      endcase
    end
  end

  // Software-written parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= ADDR_RESET_VAL;
      wdata_reg <= WDATA_RESET_VAL;
    end else if (access_phase && pwrite) begin
      if (paddr == OFS_ADDR) begin
        addr_reg <= pwdata[ADDR_W-1:0];
      end
      if (paddr == OFS_WDATA) begin
        wdata_reg <= pwdata[DATA_W-1:0];
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      op_reg <= CTRL_RESET_VAL;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
      fail_reg <= 1'b0;
      accept_reg <= 1'b0;
      issue_reg <= 1'b0;
      fail_pending_reg <= 1'b0;
      rdata_reg <= '0;
      first_reg <= '0;
      req_reg <= '0;
    end else begin
      issue_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (cmd_write) begin
            op_reg <= pwdata[2:0];
            done_reg <= 1'b0;
            pass_reg <= 1'b0;
            fail_reg <= 1'b0;
            accept_reg <= 1'b0;
            fail_pending_reg <= 1'b0;
            req_reg <= '{write: 1'b0, addr: addr_reg, wdata: wdata_reg};
            case (pwdata[2:0])
              OP_READ: begin
                state_reg <= S_READ;
                busy_reg <= 1'b1;
                issue_reg <= 1'b1;
              end
              OP_WRITE: begin
                req_reg.write <= 1'b1;
                state_reg <= S_WRITE;
                busy_reg <= 1'b1;
                issue_reg <= 1'b1;
              end
              OP_POLL: begin
                // Every new poll starts from the first read
                state_reg <= S_POLL_FIRST;
                busy_reg <= 1'b1;
                issue_reg <= 1'b1;
              end
              OP_RESET: begin
                req_reg <= '{write: 1'b1, addr: addr_reg, wdata: CMD_RESET};
                state_reg <= S_RESET_WRITE;
                busy_reg <= 1'b1;
                issue_reg <= 1'b1;
              end
              OP_SECTOR_ADD: begin
                state_reg <= S_SECT_PRE;
                busy_reg <= 1'b1;
                issue_reg <= 1'b1;
              end
              default: begin
                done_reg <= 1'b1;
              end
            endcase
          end
        end
        S_READ: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            pass_reg <= 1'b1;
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        S_WRITE: begin
          if (cyc_done) begin
            pass_reg <= 1'b1;
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        S_POLL_FIRST: begin
          if (cyc_done) begin
            first_reg <= cyc_rdata;
            issue_reg <= 1'b1;
            state_reg <= S_POLL_SECOND;
          end
        end
        S_POLL_SECOND: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            if (cyc_rdata[BIT_TOGGLE_ONE] == first_reg[BIT_TOGGLE_ONE]) begin
              pass_reg <= 1'b1;
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              state_reg <= S_IDLE;
            end else if (cyc_rdata[BIT_TIMEOUT]) begin
              first_reg <= cyc_rdata;
              issue_reg <= 1'b1;
              state_reg <= S_POLL_RECHECK;
            end else begin
              issue_reg <= 1'b1;
              state_reg <= S_POLL_FIRST;
            end
          end
        end
        S_POLL_RECHECK: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            if (cyc_rdata[BIT_TOGGLE_ONE] == first_reg[BIT_TOGGLE_ONE]) begin
              pass_reg <= 1'b1;
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              fail_pending_reg <= 1'b1;
              req_reg <= '{write: 1'b1, addr: addr_reg, wdata: CMD_RESET};
              issue_reg <= 1'b1;
              state_reg <= S_RESET_WRITE;
            end
          end
        end
        S_RESET_WRITE: begin
          if (cyc_done) begin
            fail_reg <= fail_pending_reg;
            pass_reg <= !fail_pending_reg;
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        S_SECT_PRE: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            if (cyc_rdata[BIT_ERASE_TIMER]) begin
              // Erase already under way; further sector commands would be ignored
              fail_reg <= 1'b1;
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              req_reg <= '{write: 1'b1, addr: addr_reg, wdata: CMD_SECTOR_ERASE};
              issue_reg <= 1'b1;
              state_reg <= S_SECT_WRITE;
            end
          end
        end
        S_SECT_WRITE: begin
          if (cyc_done) begin
            req_reg.write <= 1'b0;
            issue_reg <= 1'b1;
            state_reg <= S_SECT_POST;
          end
        end
        S_SECT_POST: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            accept_reg <= !cyc_rdata[BIT_ERASE_TIMER];
            pass_reg <= !cyc_rdata[BIT_ERASE_TIMER];
            fail_reg <= cyc_rdata[BIT_ERASE_TIMER];
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule : fws_ctrl
`default_nettype wire

// >>> fws_pkg.sv
// Shared constants and carrier types for the flash status-polling controller.
// Assumes a 50 MHz pclk and a byte-wide parallel NOR flash on the far side.
package fws_pkg;

  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_READ_NS = 120;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_RECOVER_NS = 30;
  localparam int SYNC_STAGES = 2;
  localparam int READ_CYCLES = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int WRITE_CYCLES = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYCLES = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // Flash geometry and status bit positions
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int BIT_TOGGLE_ONE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_ERASE_TIMER = 3;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

  // APB register map (byte offsets)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
  localparam logic [19:0] ADDR_RESET_VAL = 20'h00000;
  localparam logic [7:0] WDATA_RESET_VAL = 8'h00;

  // STATUS field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PASS = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_READY = 4;
  localparam int ST_ACCEPT = 5;
  localparam int ST_RDATA_LSB = 8;

  // Operation codes written to CTRL
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_POLL = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_SECTOR_ADD = 3'h5;

  // Flash-side strobes and buses
  typedef struct packed {
    logic chip_select_n;
    logic output_strobe_n;
    logic write_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } fws_pins_type;

  // One bus cycle request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fws_req_type;

endpackage : fws_pkg

// >>> fws_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module fws_sync
  import fws_pkg::*;
#(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[g] = stable_reg;
    end
  endgenerate

endmodule : fws_sync
`default_nettype wire

// >>> fws_cycle.sv
// Single flash bus cycle engine: one read or one write per request.
// Assumes data_in is already synchronised; strobes are framed by chip select.
`timescale 1ns/10ps
`default_nettype none
module fws_cycle
  import fws_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic start,
  input wire fws_req_type req,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // Flash side
  input wire logic [DATA_W-1:0] data_in,
  output fws_pins_type pins
);

  typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_PULSE, CYC_RECOVER} fws_cyc_type;

  fws_cyc_type state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic write_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CYC_IDLE;
      cnt_reg <= '0;
      write_reg <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      pins <= '{chip_select_n: 1'b1, output_strobe_n: 1'b1, write_strobe_n: 1'b1,
                addr: '0, data_out: '0, data_oe: 1'b0};
    end else begin
      done <= 1'b0;
      case (state_reg)
        CYC_IDLE: begin
          if (start) begin
            write_reg <= req.write;
            pins.addr <= req.addr;
            pins.data_out <= req.wdata;
            pins.data_oe <= req.write;
            pins.chip_select_n <= 1'b0;
            state_reg <= CYC_SETUP;
          end
        end
        CYC_SETUP: begin
          pins.output_strobe_n <= write_reg;
          pins.write_strobe_n <= !write_reg;
          cnt_reg <= write_reg ? CNT_W'(WRITE_CYCLES - 1) : CNT_W'(READ_CYCLES - 1);
          state_reg <= CYC_PULSE;
        end
        CYC_PULSE: begin
          if (cnt_reg == '0) begin
            if (!write_reg) begin
              rdata <= data_in;
            end
            pins.output_strobe_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
            cnt_reg <= CNT_W'(RECOVER_CYCLES - 1);
            state_reg <= CYC_RECOVER;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        CYC_RECOVER: begin
          // Chip select rises after the strobe so each read is a separate cycle
          pins.chip_select_n <= 1'b1;
          if (cnt_reg == '0) begin
            pins.data_oe <= 1'b0;
            done <= 1'b1;
            state_reg <= CYC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= CYC_IDLE;
      endcase
    end
  end

endmodule : fws_cycle
`default_nettype wire

// >>> fws_ctrl_sva.sv
// Checker for the APB slave and flash pin timing of the polling controller.
// Assumes it is bound to fws_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module fws_ctrl_sva
  import fws_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic data_lines_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access without pslverr");
  read_framed_a: assert property (!output_strobe_n |-> !chip_select_n && !data_lines_oe)
    else $error("read strobe outside chip select or with data driven");
  write_framed_a: assert property (!write_strobe_n |-> !chip_select_n && data_lines_oe)
    else $error("write strobe outside chip select or without data");
  strobe_excl_a: assert property (output_strobe_n || write_strobe_n)
    else $error("read and write strobes low together");
  read_pulse_a: assert property ($fell(output_strobe_n) |-> (!output_strobe_n)[*8] ##1 output_strobe_n)
    else $error("read strobe width wrong");
  write_pulse_a: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*3] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  select_lead_a: assert property ($fell(output_strobe_n) |-> $past(chip_select_n) == 1'b0)
    else $error("read strobe without chip select lead");
  addr_hold_a: assert property (!chip_select_n && $past(chip_select_n) == 1'b0 |-> $stable(flash_addr))
    else $error("flash address moved inside a cycle");
  select_end_a: assert property ($rose(output_strobe_n) |=> chip_select_n ##1 chip_select_n)
    else $error("chip select not released with idle gap after read");
endmodule : fws_ctrl_sva

bind fws_ctrl fws_ctrl_sva chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
  .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
  .flash_addr(flash_addr), .data_lines_oe(data_lines_oe)
);
`default_nettype wire

// >>> fws_flash_model.sv
// Behavioural flash device: status bits while busy, array data otherwise.
// Assumes the bench loads the busy length and failure mode before each operation.
`timescale 1ns/10ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
(
  // Host strobes and buses
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  // Scenario control
  input wire logic load,
  input wire logic [7:0] load_reads,
  input wire logic fail_in,
  input wire logic timer_in,
  input wire logic late_in,
  // Device side
  output logic [DATA_W-1:0] rdata,
  output logic rb_pull,
  output logic [DATA_W-1:0] last_wr
);
  logic [7:0] busy_cnt = 8'h00;
  logic tog = 1'b0;
  logic failing = 1'b0;
  logic timer = 1'b0;
  logic erasing = 1'b0;
  logic prog_bit = 1'b0;
  logic load_q = 1'b0;
  logic oe_q = 1'b1;
  logic we_q = 1'b1;
  logic [7:0] hold = 8'h00;
  logic [7:0] val;
  wire logic active = busy_cnt != 8'h00 || failing;
  wire logic poll_bit = erasing ? 1'b0 : ~prog_bit;
  wire logic [7:0] status = {poll_bit, tog, failing, 1'b0, timer, tog, 2'h0};

  assign rb_pull = active;
  // One process sees every edge, so each state variable has a single writer
  always @(load or output_strobe_n or write_strobe_n) begin
    if (load && !load_q) begin
      busy_cnt = load_reads;
      failing = fail_in;
      timer = timer_in;
    end
    // A failed operation keeps toggling until the reset command
    if (!output_strobe_n && oe_q && !chip_select_n && active) begin
      tog = ~tog;
      if (busy_cnt != 8'h00) busy_cnt = busy_cnt - 8'h01;
    end
    if (write_strobe_n && !we_q && !chip_select_n) begin
      last_wr = wdata;
      if (wdata == CMD_RESET) begin
        failing = 1'b0;
        busy_cnt = 8'h00;
        timer = 1'b0;
        erasing = 1'b0;
      end else if (wdata == CMD_SECTOR_ERASE && !timer) begin
        busy_cnt = 8'h08;
        erasing = 1'b1;
        // Window closing as the command lands leaves it unaccepted
        timer = late_in;
      end else if (!active) begin
        prog_bit = wdata[7];
      end
    end
    load_q = load;
    oe_q = output_strobe_n;
    we_q = write_strobe_n;
  end
  // Released lines show the inverse of the last driven byte
  always @* begin
    val = active ? status : addr[7:0] ^ 8'h5A;
    if (!chip_select_n && !output_strobe_n) begin
      rdata = val;
      hold = val;
    end else begin
      rdata = ~hold;
    end
  end
endmodule : fws_flash_model
`default_nettype wire

// >>> fws_ctrl_test.sv
// Self-checking bench for the flash status-polling controller.
// Assumes fws_flash_model as the flash and a pull-up on the ready line.
`timescale 1ns/10ps
`default_nettype none
module fws_ctrl_test
  import fws_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic chip_select_n, output_strobe_n, write_strobe_n, data_lines_oe, rb_pull;
  logic load, fail_in, timer_in, late_in;
  logic [7:0] paddr, load_reads;
  logic [31:0] pwdata, prdata, rd;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] data_lines_out, dev_data, last_wr;
  int failures = 0;
  int cmp_count = 0;
  wire logic [DATA_W-1:0] data_lines_in = data_lines_oe ? data_lines_out : dev_data;
  wire logic ready_busy_n = rb_pull ? 1'b0 : 1'b1;

  fws_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .flash_addr(flash_addr),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .ready_busy_n(ready_busy_n));
  fws_flash_model dev_u (.chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .addr(flash_addr), .wdata(data_lines_out),
    .load(load), .load_reads(load_reads), .fail_in(fail_in), .timer_in(timer_in),
    .late_in(late_in),
    .rdata(dev_data), .rb_pull(rb_pull), .last_wr(last_wr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask : apb

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_DONE] !== 1'b1 && n < 400);
    if (rd[ST_DONE] !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask : wait_done

  task automatic run_op(input logic [2:0] op);
    apb(1'b1, OFS_CTRL, {29'h0, op});
    wait_done();
  endtask : run_op

  task automatic set_dev(input logic [7:0] r, input logic f, input logic t);
    load_reads <= r;
    fail_in <= f;
    timer_in <= t;
    @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
  endtask : set_dev

  task automatic t_regs();
    logic [2:0] op;
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, OFS_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      op = (i == 0) ? OP_NONE : 3'(i + 5);
      run_op(op);
      check(rd[ST_FAIL:ST_BUSY], 4'h2);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, {29'h0, op});
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_read_write();
    apb(1'b1, OFS_ADDR, 32'h00123);
    run_op(OP_READ);
    check(rd[15:8], 8'h23 ^ 8'h5A);
    apb(1'b1, OFS_WDATA, 32'hC3);
    run_op(OP_WRITE);
    check(last_wr, 8'hC3);
    $display("test read write done");
  endtask : t_read_write

  task automatic t_poll_pass();
    set_dev(8'h05, 1'b0, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd[ST_READY], 1'b0);
    apb(1'b1, OFS_CTRL, {29'h0, OP_POLL});
    apb(1'b1, OFS_CTRL, {29'h0, OP_POLL});
    check(err, 1'b1);
    wait_done();
    check(rd[ST_FAIL:ST_PASS], 2'h1);
    check(rd[ST_READY], 1'b1);
    $display("test poll pass done");
  endtask : t_poll_pass

  task automatic t_poll_fail();
    set_dev(8'h00, 1'b1, 1'b0);
    run_op(OP_POLL);
    check(rd[ST_FAIL:ST_PASS], 2'h2);
    check(last_wr, CMD_RESET);
    $display("test poll fail done");
  endtask : t_poll_fail

  task automatic t_sector();
    set_dev(8'h08, 1'b0, 1'b0);
    apb(1'b1, OFS_ADDR, 32'h40000);
    run_op(OP_SECTOR_ADD);
    check(rd[ST_ACCEPT:ST_PASS], 4'h9);
    check(last_wr, CMD_SECTOR_ERASE);
    apb(1'b1, OFS_WDATA, 32'h3C);
    run_op(OP_WRITE);
    set_dev(8'h08, 1'b0, 1'b1);
    run_op(OP_SECTOR_ADD);
    check(rd[ST_ACCEPT:ST_PASS], 4'h2);
    check(last_wr, 8'h3C);
    run_op(OP_RESET);
    check(last_wr, CMD_RESET);
    set_dev(8'h08, 1'b0, 1'b0);
    late_in <= 1'b1;
    run_op(OP_SECTOR_ADD);
    late_in <= 1'b0;
    check(rd[ST_ACCEPT:ST_PASS], 4'h2);
    check(last_wr, CMD_SECTOR_ERASE);
    $display("test sector done");
  endtask : t_sector

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load = 1'b0;
    load_reads = 8'h00;
    fail_in = 1'b0;
    timer_in = 1'b0;
    late_in = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_read_write();
    t_poll_pass();
    t_poll_fail();
    t_sector();
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule : fws_ctrl_test
`default_nettype wire
